/* common/cfg_startup_pkg.sv */
// package: constants for the configuration start-up sequencer
`default_nettype none
package cfg_startup_pkg;
	localparam int AW = 5;
	localparam int LOCKS = 4;

	// register byte offsets
	localparam logic [AW-1:0] OFF_OPT      = 5'h00;
	localparam logic [AW-1:0] OFF_CMD      = 5'h04;
	localparam logic [AW-1:0] OFF_CRC_EXP  = 5'h08;
	localparam logic [AW-1:0] OFF_CRC_CALC = 5'h0c;
	localparam logic [AW-1:0] OFF_TAG      = 5'h10;
	localparam logic [AW-1:0] OFF_STAT     = 5'h14;

	// option register fields
	localparam int CMPL_LSB  = 0;
	localparam int OE_LSB    = 3;
	localparam int FLOP_LSB  = 6;
	localparam int WE_LSB    = 9;
	localparam int LOCK_LSB  = 12;
	localparam int CLK_LSB   = 15;
	localparam int SYNC_BIT  = 17;
	localparam int DRIVE_BIT = 18;
	localparam int KEEP_BIT  = 19;
	localparam int PAR_BIT   = 20;
	localparam int SEC_LSB   = 21;
	localparam int LSEL_LSB  = 23;

	localparam logic [2:0] PH_FOLLOW   = 3'h7;
	localparam logic [2:0] PH_NO_WAIT  = 3'h7;
	localparam logic [2:0] PH_LAST     = 3'h7;
	localparam logic [2:0] CMPL_PH_DEF = 3'h4;
	localparam logic [2:0] OE_PH_DEF   = 3'h5;
	localparam logic [2:0] FLOP_PH_DEF = 3'h6;
	localparam logic [2:0] WE_PH_DEF   = 3'h6;

	localparam logic [1:0] CLK_CONFIG = 2'h0;
	localparam logic [1:0] CLK_DESIGN = 2'h1;
	localparam logic [1:0] CLK_SCAN   = 2'h2;
	localparam logic [1:0] SEC_NONE   = 2'h0;
	localparam logic [1:0] SEC_L1     = 2'h1;
	localparam logic [1:0] SEC_L2     = 2'h2;

	localparam logic [31:0] OPT_RESET = {7'h00, 2'h0, SEC_NONE, 4'h0, CLK_CONFIG, PH_NO_WAIT,
		WE_PH_DEF, FLOP_PH_DEF, OE_PH_DEF, CMPL_PH_DEF};
	localparam logic [31:0] TAG_RESET = 32'hffff_ffff;

	// command register bits
	localparam int CMD_SYNC      = 0;
	localparam int CMD_CRC_FIRST = 1;
	localparam int CMD_CRC_LAST  = 2;

	// status register fields
	localparam int ST_CLR_BIT = 0;
	localparam int ST_ERR_BIT = 1;
	localparam int ST_SEQ_BIT = 2;
	localparam int ST_RUN_BIT = 3;
	localparam int ST_PH_LSB  = 4;
	localparam int ST_MD_LSB  = 7;
	localparam int ST_SEC_LSB = 10;

	localparam int CLK_NS        = 50;
	localparam int CLEAR_MIN_NS  = 300;
	localparam int CLEAR_MIN_CYC = (CLEAR_MIN_NS + CLK_NS - 1) / CLK_NS;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {ST_CLEAR, ST_WAIT_INIT, ST_WAIT_SYNC, ST_LOAD, ST_STARTUP, ST_RUN, ST_ERROR}
		cfg_state_e;
endpackage
`default_nettype wire

/* design/pin_sync.sv */
// two-flop synchroniser for pins and foreign clocks
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // pin_sync
`default_nettype wire

/* design/config_startup_sequencer.sv */
// configuration start-up sequencer with memory clear, crc abort and security
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`default_nettype none
// Behaviour
// - write enable released at its chosen phase; while off, state is frozen
// - write enable set to follow completion rises with the pin, or one edge later
// - outputs held disabled until the output-enable phase
// - output-enable following completion drops with the pin rise, or one edge later
// - no lock stall by default; chosen phase waits for selected loop lock
// - configuration pins become user pins unless keep option set
// - completion pin open-drain by default, actively driven with drive option
// - after releasing completion, wait to see pin high before advancing
// - completion sync option adds one register stage on the pin
// - level 1 refuses all readback, parallel and scan
// - level 2 refuses all configuration and readback everywhere
// - security clears only through the clear pin or power cycle
// - 32-bit user tag word returned for the scan usercode request
// - start-up triggered by command, never by counting clock cycles
// - eight phases, 0 to 7, each action at its configured phase
// - end-of-start-up flag always set in phase 7, internal only
// - completion wait never delays actions configured earlier
// - after power-up memory cleared with status pin low, then released
// - clear pin low resets and clears; other side holds it 300 ns
// - status pin held low delays; mode sampled at rise; pre-sync data ignored
// - crc checked twice; mismatch drives status pin low and aborts
// - flops held at initial values until the flop-release phase
// - sequencer clock chosen from configuration, design or scan clock
module config_startup_sequencer #(
	parameter int CLEAR_CYCLES = 64
) (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [cfg_startup_pkg::AW-1:0]    awaddr,
	input  wire logic                              awvalid,
	output logic                                   awready,
	input  wire logic [31:0]                       wdata,
	input  wire logic [3:0]                        wstrb,
	input  wire logic                              wvalid,
	output logic                                   wready,
	output logic [1:0]                             bresp,
	output logic                                   bvalid,
	input  wire logic                              bready,
	input  wire logic [cfg_startup_pkg::AW-1:0]    araddr,
	input  wire logic                              arvalid,
	output logic                                   arready,
	output logic [31:0]                            rdata,
	output logic [1:0]                             rresp,
	output logic                                   rvalid,
	input  wire logic                              rready,
	input  wire logic                              clear_n_pin,
	input  wire logic                              memclr_pin_in,
	output logic                                   memclr_pin_out,
	output logic                                   memclr_pin_oe_n,
	input  wire logic                              cmpl_pin_in,
	output logic                                   cmpl_pin_out,
	output logic                                   cmpl_pin_oe_n,
	input  wire logic [2:0]                        mode_pins,
	input  wire logic                              config_clock,
	input  wire logic                              design_clock,
	input  wire logic                              scan_clock,
	input  wire logic [cfg_startup_pkg::LOCKS-1:0] dll_lock,
	input  wire logic                              readback_req,
	input  wire logic                              readback_via_scan,
	input  wire logic                              config_req,
	input  wire logic                              config_via_scan,
	input  wire logic                              usercode_req,
	output logic                                   readback_grant,
	output logic                                   config_grant,
	output logic [31:0]                            usercode,
	output logic                                   global_write_enable,
	output logic                                   global_output_disable,
	output logic                                   global_flop_reset,
	output logic                                   user_io_release
);
	localparam int SW = 14 + cfg_startup_pkg::LOCKS;

	logic [SW-1:0] sync_s;
	logic clear_n_s, memclr_s, cmpl_s, config_clock_s, dclk_s, sclk_s;
	logic rb_req_s, rb_scan_s, cf_req_s, cf_scan_s, uc_req_s;
	logic [2:0] mode_s;
	logic [cfg_startup_pkg::LOCKS-1:0] lock_s;

	cfg_startup_pkg::cfg_state_e state_q;
	logic [2:0]  phase_q;
	logic [15:0] clr_cnt_q;
	logic [7:0]  low_cnt_q;
	logic [31:0] opt_q, crc_exp_q, crc_calc_q, tag_q;
	logic [2:0]  mode_q;
	logic        crc_err_q, eos_q, seq_prev_q, cmpl_pipe_q;
	logic        aw_got_q, w_got_q;
	logic [cfg_startup_pkg::AW-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;

	logic [2:0]  cmpl_ph, oe_ph, flop_ph, we_ph, lock_ph;
	logic [1:0]  clk_sel, sec, lock_sel, sec_new;
	logic        sync_on, drive_on, keep_on, par_on;
	logic        seq_clk, step, cmpl_seen, lock_ok, stall, started, running, clr_hold;
	logic        wr_fire, cmd_wr, release_cmpl;
	logic [31:0] opt_new, rd_mux;

	function automatic logic [cfg_startup_pkg::AW-1:0] word(input logic [cfg_startup_pkg::AW-1:0] a);
		return {a[cfg_startup_pkg::AW-1:2], 2'h0};
	endfunction

	function automatic logic mapped(input logic [cfg_startup_pkg::AW-1:0] a);
		logic [cfg_startup_pkg::AW-1:0] w;
		w = word(a);
		return w == cfg_startup_pkg::OFF_OPT || w == cfg_startup_pkg::OFF_CMD
			|| w == cfg_startup_pkg::OFF_CRC_EXP || w == cfg_startup_pkg::OFF_CRC_CALC
			|| w == cfg_startup_pkg::OFF_TAG || w == cfg_startup_pkg::OFF_STAT;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// a follow-completion setting tracks the seen pin, otherwise the phase count
	function automatic logic reached(input logic [2:0] ph, input logic [2:0] sel, input logic seen);
		return (sel == cfg_startup_pkg::PH_FOLLOW) ? seen : (ph >= sel);
	endfunction

	pin_sync #(.W(SW)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({clear_n_pin, memclr_pin_in, cmpl_pin_in, config_clock, design_clock, scan_clock,
			mode_pins, dll_lock, readback_req, readback_via_scan, config_req, config_via_scan,
			usercode_req}),
		.q       (sync_s)
	);

	assign {clear_n_s, memclr_s, cmpl_s, config_clock_s, dclk_s, sclk_s, mode_s, lock_s,
		rb_req_s, rb_scan_s, cf_req_s, cf_scan_s, uc_req_s} = sync_s;

	assign cmpl_ph  = opt_q[cfg_startup_pkg::CMPL_LSB +: 3];
	assign oe_ph    = opt_q[cfg_startup_pkg::OE_LSB +: 3];
	assign flop_ph  = opt_q[cfg_startup_pkg::FLOP_LSB +: 3];
	assign we_ph    = opt_q[cfg_startup_pkg::WE_LSB +: 3];
	assign lock_ph  = opt_q[cfg_startup_pkg::LOCK_LSB +: 3];
	assign clk_sel  = opt_q[cfg_startup_pkg::CLK_LSB +: 2];
	assign sec      = opt_q[cfg_startup_pkg::SEC_LSB +: 2];
	assign lock_sel = opt_q[cfg_startup_pkg::LSEL_LSB +: 2];
	assign sync_on  = opt_q[cfg_startup_pkg::SYNC_BIT];
	assign drive_on = opt_q[cfg_startup_pkg::DRIVE_BIT];
	assign keep_on  = opt_q[cfg_startup_pkg::KEEP_BIT];
	assign par_on   = opt_q[cfg_startup_pkg::PAR_BIT];

	assign started  = state_q == cfg_startup_pkg::ST_STARTUP || state_q == cfg_startup_pkg::ST_RUN;
	assign running  = state_q == cfg_startup_pkg::ST_RUN;
	// short glitches on the clear pin are filtered by the minimum low time
	assign clr_hold = low_cnt_q == 8'(cfg_startup_pkg::CLEAR_MIN_CYC);

	always_comb begin
		case (clk_sel)
			cfg_startup_pkg::CLK_DESIGN: seq_clk = dclk_s;
			cfg_startup_pkg::CLK_SCAN:   seq_clk = sclk_s;
			default:                     seq_clk = config_clock_s;
		endcase
	end

	assign step      = seq_clk & ~seq_prev_q;
	assign cmpl_seen = sync_on ? cmpl_pipe_q : cmpl_s;
	assign lock_ok   = lock_s[lock_sel];
	assign stall     = (phase_q == cmpl_ph && !cmpl_seen)
		|| (lock_ph != cfg_startup_pkg::PH_NO_WAIT && phase_q == lock_ph && !lock_ok);
	assign release_cmpl = started && phase_q >= cmpl_ph;

	assign wr_fire = aw_got_q && w_got_q && !bvalid;
	assign cmd_wr  = wr_fire && word(waddr_q) == cfg_startup_pkg::OFF_CMD;
	assign opt_new = merge(opt_q, wdata_q, wstrb_q);
	// a written level can only raise security, never lower it
	assign sec_new = (opt_new[cfg_startup_pkg::SEC_LSB +: 2] > sec) ? opt_new[cfg_startup_pkg::SEC_LSB +: 2] : sec;

	always_comb begin
		rd_mux = 32'h0;
		case (word(araddr))
			cfg_startup_pkg::OFF_OPT:      rd_mux = opt_q;
			cfg_startup_pkg::OFF_CRC_EXP:  rd_mux = crc_exp_q;
			cfg_startup_pkg::OFF_CRC_CALC: rd_mux = crc_calc_q;
			cfg_startup_pkg::OFF_TAG:      rd_mux = tag_q;
			cfg_startup_pkg::OFF_STAT: begin
				rd_mux[cfg_startup_pkg::ST_CLR_BIT]      = state_q == cfg_startup_pkg::ST_CLEAR;
				rd_mux[cfg_startup_pkg::ST_ERR_BIT]      = crc_err_q;
				rd_mux[cfg_startup_pkg::ST_SEQ_BIT]      = state_q == cfg_startup_pkg::ST_STARTUP;
				rd_mux[cfg_startup_pkg::ST_RUN_BIT]      = running;
				rd_mux[cfg_startup_pkg::ST_PH_LSB +: 3]  = phase_q;
				rd_mux[cfg_startup_pkg::ST_MD_LSB +: 3]  = mode_q;
				rd_mux[cfg_startup_pkg::ST_SEC_LSB +: 2] = sec;
			end
			default: rd_mux = 32'h0;
		endcase
	end

	// write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready  <= 1'h1;
			wready   <= 1'h1;
			aw_got_q <= 1'h0;
			w_got_q  <= 1'h0;
			waddr_q  <= '0;
			wdata_q  <= 32'h0;
			wstrb_q  <= 4'h0;
			bvalid   <= 1'h0;
			bresp    <= cfg_startup_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awready  <= 1'h0;
				aw_got_q <= 1'h1;
				waddr_q  <= awaddr;
			end
			if (wvalid && wready) begin
				wready  <= 1'h0;
				w_got_q <= 1'h1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_fire) begin
				aw_got_q <= 1'h0;
				w_got_q  <= 1'h0;
				awready  <= 1'h1;
				wready   <= 1'h1;
				bvalid   <= 1'h1;
				bresp    <= mapped(waddr_q) ? cfg_startup_pkg::RESP_OKAY : cfg_startup_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'h0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'h1;
			rvalid  <= 1'h0;
			rdata   <= 32'h0;
			rresp   <= cfg_startup_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'h0;
			rvalid  <= 1'h1;
			rdata   <= rd_mux;
			rresp   <= mapped(araddr) ? cfg_startup_pkg::RESP_OKAY : cfg_startup_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'h0;
			arready <= 1'h1;
		end
	end

	// options are frozen once start-up begins
	always_ff @(posedge aclk) begin
		if (!aresetn || state_q == cfg_startup_pkg::ST_CLEAR) begin
			opt_q      <= cfg_startup_pkg::OPT_RESET;
			crc_exp_q  <= 32'h0;
			crc_calc_q <= 32'h0;
			tag_q      <= cfg_startup_pkg::TAG_RESET;
		end else if (wr_fire) begin
			case (word(waddr_q))
				cfg_startup_pkg::OFF_OPT: begin
					if (!started) begin
						opt_q <= {opt_new[31:cfg_startup_pkg::SEC_LSB+2], sec_new, opt_new[cfg_startup_pkg::SEC_LSB-1:0]};
					end
				end
				cfg_startup_pkg::OFF_CRC_EXP:  crc_exp_q <= merge(crc_exp_q, wdata_q, wstrb_q);
				cfg_startup_pkg::OFF_CRC_CALC: crc_calc_q <= merge(crc_calc_q, wdata_q, wstrb_q);
				cfg_startup_pkg::OFF_TAG: begin
					if (state_q == cfg_startup_pkg::ST_LOAD) begin
						tag_q <= merge(tag_q, wdata_q, wstrb_q);
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_cnt_q   <= 8'h0;
			seq_prev_q  <= 1'h0;
			cmpl_pipe_q <= 1'h0;
		end else begin
			if (clear_n_s) begin
				low_cnt_q <= 8'h0;
			end else if (!clr_hold) begin
				low_cnt_q <= low_cnt_q + 8'h1;
			end
			seq_prev_q <= seq_clk;
			// a stale pipe from an earlier start-up would fake a completion rise
			if (!started) begin
				cmpl_pipe_q <= 1'h0;
			end else if (step) begin
				cmpl_pipe_q <= cmpl_s;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= cfg_startup_pkg::ST_CLEAR;
			clr_cnt_q <= 16'h0;
			phase_q   <= 3'h0;
			crc_err_q <= 1'h0;
			eos_q     <= 1'h0;
			mode_q    <= 3'h0;
		end else if (clr_hold) begin
			state_q   <= cfg_startup_pkg::ST_CLEAR;
			clr_cnt_q <= 16'h0;
			phase_q   <= 3'h0;
			crc_err_q <= 1'h0;
			eos_q     <= 1'h0;
		end else begin
			case (state_q)
				cfg_startup_pkg::ST_CLEAR: begin
					if (clr_cnt_q == 16'(CLEAR_CYCLES - 1)) begin
						state_q <= cfg_startup_pkg::ST_WAIT_INIT;
					end else begin
						clr_cnt_q <= clr_cnt_q + 16'h1;
					end
				end
				cfg_startup_pkg::ST_WAIT_INIT: begin
					if (memclr_s) begin
						mode_q  <= mode_s;
						state_q <= cfg_startup_pkg::ST_WAIT_SYNC;
					end
				end
				cfg_startup_pkg::ST_WAIT_SYNC: begin
					if (cmd_wr && wdata_q[cfg_startup_pkg::CMD_SYNC]) begin
						state_q <= cfg_startup_pkg::ST_LOAD;
					end
				end
				cfg_startup_pkg::ST_LOAD: begin
					if (cmd_wr && (wdata_q[cfg_startup_pkg::CMD_CRC_FIRST] || wdata_q[cfg_startup_pkg::CMD_CRC_LAST])) begin
						if (crc_exp_q != crc_calc_q) begin
							crc_err_q <= 1'h1;
							state_q   <= cfg_startup_pkg::ST_ERROR;
						end else if (wdata_q[cfg_startup_pkg::CMD_CRC_LAST]) begin
							state_q <= cfg_startup_pkg::ST_STARTUP;
							phase_q <= 3'h0;
						end
					end
				end
				cfg_startup_pkg::ST_STARTUP: begin
					if (step && !stall) begin
						phase_q <= phase_q + 3'h1;
						if (phase_q == cfg_startup_pkg::PH_LAST - 3'h1) begin
							eos_q   <= 1'h1;
							state_q <= cfg_startup_pkg::ST_RUN;
						end
					end
				end
				cfg_startup_pkg::ST_RUN, cfg_startup_pkg::ST_ERROR: ;
				default: state_q <= cfg_startup_pkg::ST_CLEAR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_write_enable   <= 1'h0;
			global_output_disable <= 1'h1;
			global_flop_reset     <= 1'h1;
			user_io_release       <= 1'h0;
			memclr_pin_out        <= 1'h0;
			memclr_pin_oe_n       <= 1'h0;
			cmpl_pin_out          <= 1'h0;
			cmpl_pin_oe_n         <= 1'h0;
			readback_grant        <= 1'h0;
			config_grant          <= 1'h0;
			usercode              <= 32'h0;
		end else begin
			global_write_enable   <= started && reached(phase_q, we_ph, cmpl_seen);
			global_output_disable <= !(started && reached(phase_q, oe_ph, cmpl_seen));
			global_flop_reset     <= !(started && reached(phase_q, flop_ph, cmpl_seen));
			user_io_release       <= running && !keep_on;
			memclr_pin_out        <= 1'h0;
			memclr_pin_oe_n       <= !(state_q == cfg_startup_pkg::ST_CLEAR || state_q == cfg_startup_pkg::ST_ERROR);
			cmpl_pin_out          <= drive_on && release_cmpl;
			cmpl_pin_oe_n         <= !drive_on && release_cmpl;
			// parallel readback needs the pins kept in parallel form
			readback_grant <= rb_req_s && sec == cfg_startup_pkg::SEC_NONE
				&& (rb_scan_s || !running || (keep_on && par_on));
			config_grant <= cf_req_s && sec != cfg_startup_pkg::SEC_L2 && (cf_scan_s || !running || keep_on);
			if (uc_req_s) begin
				usercode <= tag_q;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_crc_bad;
		state_q == cfg_startup_pkg::ST_LOAD && !clr_hold && cmd_wr && crc_exp_q != crc_calc_q
			&& (wdata_q[cfg_startup_pkg::CMD_CRC_FIRST] || wdata_q[cfg_startup_pkg::CMD_CRC_LAST]);
	endsequence
	sequence s_aborted;
		state_q == cfg_startup_pkg::ST_ERROR ##1 (!memclr_pin_oe_n && !global_write_enable);
	endsequence
	property p_crc_abort;
		s_crc_bad |=> s_aborted;
	endproperty
	a_crc_abort: assert property (p_crc_abort) else $error("crc mismatch did not abort");

	property p_we_phase;
		$rose(global_write_enable) |-> we_ph == cfg_startup_pkg::PH_FOLLOW || $past(phase_q) >= we_ph;
	endproperty
	a_we_phase: assert property (p_we_phase) else $error("write enable before its phase");

	property p_we_follow;
		started && !clr_hold && we_ph == cfg_startup_pkg::PH_FOLLOW && !sync_on && $rose(cmpl_s)
			|=> global_write_enable;
	endproperty
	a_we_follow: assert property (p_we_follow) else $error("write enable missed completion rise");

	property p_oe_hold;
		!started |=> global_output_disable;
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("outputs enabled before start-up");

	property p_oe_sync;
		started && !clr_hold && oe_ph == cfg_startup_pkg::PH_FOLLOW && sync_on && step && cmpl_s
			|=> ##1 !global_output_disable;
	endproperty
	a_oe_sync: assert property (p_oe_sync) else $error("output enable missed synced completion");

	property p_lock_stall;
		state_q == cfg_startup_pkg::ST_STARTUP && !clr_hold && lock_ph != cfg_startup_pkg::PH_NO_WAIT
			&& phase_q == lock_ph && !lock_ok |=> phase_q == $past(phase_q);
	endproperty
	a_lock_stall: assert property (p_lock_stall) else $error("advanced without loop lock");

	property p_cmpl_stall;
		state_q == cfg_startup_pkg::ST_STARTUP && !clr_hold && phase_q == cmpl_ph && !cmpl_seen
			|=> phase_q == $past(phase_q);
	endproperty
	a_cmpl_stall: assert property (p_cmpl_stall) else $error("advanced before completion seen");

	property p_one_step;
		(state_q == cfg_startup_pkg::ST_STARTUP && !clr_hold) ##1 (phase_q != $past(phase_q))
			|-> phase_q == $past(phase_q) + 3'h1 && $past(step);
	endproperty
	a_one_step: assert property (p_one_step) else $error("phase moved without a clock edge");

	property p_eos;
		$rose(eos_q) |-> phase_q == cfg_startup_pkg::PH_LAST && state_q == cfg_startup_pkg::ST_RUN;
	endproperty
	a_eos: assert property (p_eos) else $error("end flag outside final phase");

	property p_sec2;
		sec == cfg_startup_pkg::SEC_L2 |=> !config_grant && !readback_grant;
	endproperty
	a_sec2: assert property (p_sec2) else $error("access granted at level 2");

	property p_clear;
		clr_hold |=> state_q == cfg_startup_pkg::ST_CLEAR ##1 !memclr_pin_oe_n;
	endproperty
	a_clear: assert property (p_clear) else $error("clear pin not obeyed");

	property p_open_drain;
		!drive_on |=> !cmpl_pin_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("completion pin driven high");
endmodule // config_startup_sequencer
`default_nettype wire

/* verif/cfg_source_model.sv */
// model of the external configuration source on the status, completion and clock pins
`default_nettype none
module cfg_source_model (
	input  wire logic clk_run,
	input  wire logic hold_memclr,
	input  wire logic memclr_oe_n,
	input  wire logic cmpl_oe_n,
	input  wire logic cmpl_out,
	output logic      config_clock,
	output logic      memclr_wire,
	output logic      cmpl_wire
);
	timeunit 1ns;
	timeprecision 1ns;
	// both wires have pull-ups; either party may pull the status wire low, only the sequencer the completion wire
	assign memclr_wire = !hold_memclr && memclr_oe_n;
	assign cmpl_wire = cmpl_oe_n ? 1'b1 : cmpl_out;
	// clock stands still while clk_run is low, so no edges leak in
	initial begin
		config_clock = 1'b0;
		forever #200 config_clock = clk_run ? !config_clock : 1'b0;
	end
endmodule // cfg_source_model
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the start-up sequencer
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] CMD = cfg_startup_pkg::OFF_CMD;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, usercode, rd_d;
	logic [3:0] wstrb, dll_lock;
	logic [1:0] bresp, rresp, rd_r;
	logic [2:0] mode_pins;
	logic clear_n_pin, memclr_pin_in, memclr_pin_out, memclr_pin_oe_n, cmpl_pin_in, cmpl_pin_out, cmpl_pin_oe_n;
	logic config_clock, design_clock, scan_clock, readback_req, readback_via_scan, config_req, config_via_scan;
	logic usercode_req, readback_grant, config_grant, global_write_enable, global_output_disable;
	logic global_flop_reset, user_io_release, clk_run, hold_memclr;
	int n_fail = 0;
	int samples_checked = 0;
	config_startup_sequencer #(.CLEAR_CYCLES(8)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .clear_n_pin, .memclr_pin_in, .memclr_pin_out, .memclr_pin_oe_n, .cmpl_pin_in,
		.cmpl_pin_out, .cmpl_pin_oe_n, .mode_pins, .config_clock, .design_clock, .scan_clock, .dll_lock,
		.readback_req, .readback_via_scan, .config_req, .config_via_scan, .usercode_req, .readback_grant,
		.config_grant, .usercode, .global_write_enable, .global_output_disable, .global_flop_reset,
		.user_io_release);
	cfg_source_model partner (.clk_run, .hold_memclr, .memclr_oe_n(memclr_pin_oe_n), .cmpl_oe_n(cmpl_pin_oe_n),
		.cmpl_out(cmpl_pin_out), .config_clock, .memclr_wire(memclr_pin_in), .cmpl_wire(cmpl_pin_in));
	task automatic end_sim();
		$display("compared %0d mismatched %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wt(ref logic s, input logic v, input string nm);
		logic ok;
		ok = 1'b0;
		for (int n = 0; n < 2000 && !ok; n++) begin
			@(negedge aclk);
			ok = s === v;
		end
		chk(nm, 32'(v), 32'(s));
		@(posedge aclk);
		if (!ok) end_sim();
	endtask
	// releases each channel only after the edge that took it
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		for (int n = 0; n < 50 && !tb; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		if (!tb) end_sim();
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		for (int n = 0; n < 50 && !tr; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		if (!tr) end_sim();
	endtask
	task automatic s_reset();
		chk("output disable", 1, global_output_disable);
		chk("write enable", 0, global_write_enable);
		wt(memclr_pin_oe_n, 1'b1, "memclr released");
		rd(cfg_startup_pkg::OFF_TAG, rd_d, rd_r);
		chk("tag reset", cfg_startup_pkg::TAG_RESET, rd_d);
		rd(5'h18, rd_d, rd_r);
		chk("unmapped resp", 32'(cfg_startup_pkg::RESP_SLVERR), 32'(rd_r));
	endtask
	task automatic s_crc();
		wr(CMD, 32'h1);
		wr(cfg_startup_pkg::OFF_CRC_EXP, 32'h1);
		wr(cfg_startup_pkg::OFF_CRC_CALC, 32'h2);
		wr(CMD, 32'h2);
		wt(memclr_pin_oe_n, 1'b0, "crc abort");
		chk("no start", 0, global_write_enable);
	endtask
	task automatic s_clear();
		clear_n_pin <= 1'b0;
		hold_memclr <= 1'b1;
		repeat (8) @(posedge aclk);
		clear_n_pin <= 1'b1;
		repeat (20) @(posedge aclk);
		mode_pins <= 3'h3;
		hold_memclr <= 1'b0;
		wt(memclr_pin_oe_n, 1'b1, "clear done");
		repeat (6) @(posedge aclk);
		rd(cfg_startup_pkg::OFF_STAT, rd_d, rd_r);
		chk("mode", 32'h3, 32'(rd_d[cfg_startup_pkg::ST_MD_LSB +: 3]));
	endtask
	task automatic s_start();
		wr(CMD, 32'h1);
		wr(cfg_startup_pkg::OFF_TAG, 32'h1234_abcd);
		wr(cfg_startup_pkg::OFF_CRC_EXP, 32'h5a);
		wr(cfg_startup_pkg::OFF_CRC_CALC, 32'h5a);
		clk_run <= 1'b1;
		readback_req <= 1'b1;
		config_req <= 1'b1;
		wr(CMD, 32'h4);
		wt(global_write_enable, 1'b1, "write enable");
		chk("outputs on", 0, global_output_disable);
		chk("flop release", 0, global_flop_reset);
		chk("cmpl open drain", 1, cmpl_pin_oe_n);
		wt(user_io_release, 1'b1, "user pins");
		usercode_req <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("usercode", 32'h1234_abcd, usercode);
		chk("no readback", 0, readback_grant);
		chk("no reconfig", 0, config_grant);
	endtask
	task automatic s_opts();
		s_clear();
		wr(cfg_startup_pkg::OFF_OPT, 32'h01be_2fbc);
		wr(CMD, 32'h1);
		wr(CMD, 32'h4);
		repeat (40) @(posedge aclk);
		rd(cfg_startup_pkg::OFF_STAT, rd_d, rd_r);
		chk("lock stall", 32'h2, 32'(rd_d[cfg_startup_pkg::ST_PH_LSB +: 3]));
		chk("held disable", 1, global_output_disable);
		dll_lock <= 4'h8;
		wt(global_write_enable, 1'b1, "we follow");
		chk("oe follow", 0, global_output_disable);
		chk("cmpl drive", 1, cmpl_pin_out);
		repeat (40) @(posedge aclk);
		chk("pins kept", 0, user_io_release);
		chk("level 1 readback", 0, readback_grant);
		chk("kept config", 1, config_grant);
		s_clear();
		rd(cfg_startup_pkg::OFF_STAT, rd_d, rd_r);
		chk("security cleared", 0, 32'(rd_d[cfg_startup_pkg::ST_SEC_LSB +: 2]));
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = !aclk;
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, design_clock, scan_clock, readback_req} = '0;
		{readback_via_scan, config_req, config_via_scan, usercode_req, clk_run, hold_memclr} = '0;
		{awaddr, araddr, wdata, wstrb, dll_lock} = '0;
		mode_pins = 3'h5;
		clear_n_pin = 1'b1;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		s_reset();
		s_crc();
		s_clear();
		s_start();
		s_opts();
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
